/* File: verilog/supervisor_profile_flash_ctl.sv */
// Purpose: profile sequencing, save delay, overtemperature and restart control
// Assumes: register strobes one cycle long, inputs synchronous to clk
// Notes: one sequencer serves all channels in turn through one table port
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
module supervisor_profile_flash_ctl
   import supervisor_pkg::*;
#(
   parameter int NCH = 2,
   parameter int TICK_CYC = TICK_CYCLES,
   parameter logic [TEMP_W-1:0] TEMP_LIMIT = 12'h320,
   parameter logic [TEMP_W-1:0] DERATE_START = 12'h2bc,
   parameter logic [15:0] CUR_MAX = 16'h0fa0,
   parameter logic [15:0] DERATE_SLOPE = 16'h0028
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData_q,
   // Start lines
   input wire logic [NCH-1:0] generalInputLine,
   // Device temperature and external faults
   input wire logic [TEMP_W-1:0] deviceTemp,
   input wire logic faultEvent,
   input wire errInfo_type faultInfo,
   // Channel outputs and the device current limit
   output logic [NCH-1:0][TEMP_W-1:0] targetOut_q,
   output logic [NCH-1:0] outEnable_q,
   output logic [NCH-1:0] running_q,
   output logic [15:0] currentLimit_q,
   // Supervisor outputs
   output logic flashSave_q,
   output logic errorState_q,
   output logic irq_q
);
   localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

   chanCfg_type cfg_q [NCH];
   logic [1:0] ctrl_q;
   logic [15:0] restartDelay_q;
   logic [CW-1:0] chanSel_q;
   logic [TAB_AW-1:0] tabAddr_q;
   logic [IRQ_W-1:0] irqStat_q;
   logic [IRQ_W-1:0] irqMask_q;
   logic [NCH-1:0] lineLast_q;
   logic [23:0] tickCnt_q;
   logic tick_q;
   logic [9:0] msCnt_q;
   logic secTick_q;
   logic [15:0] flashCnt_q;
   logic dirty_q;
   logic [15:0] sampleCnt_q;
   logic [TEMP_W-1:0] tempSample_q;
   errInfo_type errInfo_q;
   logic [15:0] errSec_q;
   logic [4:0] upSec_q;
   seqState_type seq_q;
   logic [CW-1:0] cur_q;
   logic [TAB_AW-1:0] pc_q [NCH];
   logic [7:0] repLeft_q [NCH];
   logic [15:0] wait_q [NCH];
   logic [TEMP_W-1:0] savedTarget_q [NCH];
   logic [NCH-1:0] savedEnable_q;
   logic [NCH-1:0] doneEvt_q;
   logic restartEvt;
   logic errorEvt;
   logic [31:0] memRd;
   entry_type entry;
   logic paramChange;
   logic [NCH-1:0] startReq;
   logic [NCH-1:0] stopReq;
   logic candFound;
   logic [CW-1:0] candIdx;
   logic [TAB_AW-1:0] memRdAddr;
   logic [15:0] derated;

   function automatic logic wrAt(input logic [7:0] off);
      return regWrite && (regAddr == off);
   endfunction

   // Extended mode derating curve
   function automatic logic [15:0] derate(input logic [TEMP_W-1:0] t);
      logic [31:0] over;
      over = 32'h0;
      if (t <= DERATE_START) begin
         return CUR_MAX;
      end
      over = 32'(t - DERATE_START) * 32'(DERATE_SLOPE);
      if (over >= 32'(CUR_MAX)) begin
         return 16'h0;
      end
      return CUR_MAX - over[15:0];
   endfunction

   assign entry = entry_type'(memRd);
   assign derated = derate(tempSample_q);
   assign paramChange = wrAt(REG_CTRL) || wrAt(REG_CH_TABLE) || wrAt(REG_CH_REPEAT) ||
                        wrAt(REG_CH_TARGET) || wrAt(REG_RESTART_DLY) || wrAt(REG_TAB_DATA);

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         startReq[c] = (wrAt(REG_CMD) && regWrData[CMD_START_BIT] &&
                        regWrData[CW-1:0] == CW'(c)) ||
                       (generalInputLine[c] && !lineLast_q[c]);
         stopReq[c] = wrAt(REG_CMD) && regWrData[CMD_STOP_BIT] &&
                      regWrData[CW-1:0] == CW'(c);
      end
   end

   // Round robin pick of a channel ready to fetch
   always_comb begin
      int idx;
      idx = 0;
      candFound = 1'b0;
      candIdx = '0;
      for (int i = NCH; i >= 1; i--) begin
         idx = (int'(cur_q) + i) % NCH;
         if (running_q[idx] && wait_q[idx] == 16'h0) begin
            candFound = 1'b1;
            candIdx = CW'(idx);
         end
      end
   end

   assign memRdAddr = cfg_q[cur_q].tableBase + pc_q[cur_q];

   profile_mem #(.DEPTH(1 << TAB_AW), .WIDTH(32), .AW(TAB_AW)) u_mem (
      .clk(clk),
      .wrEn(wrAt(REG_TAB_DATA)),
      .wrAddr(tabAddr_q),
      .wrData(regWrData),
      .rdEn(seq_q == SEQ_READ),
      .rdAddr(memRdAddr),
      .rdData_q(memRd)
   );

   // Software registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_q <= CTRL_RESET;
         restartDelay_q <= 16'h0;
         chanSel_q <= '0;
         tabAddr_q <= '0;
         irqMask_q <= '0;
         for (int c = 0; c < NCH; c++) begin
            cfg_q[c] <= '0;
         end
      end else begin
         if (wrAt(REG_CTRL)) ctrl_q <= regWrData[1:0];
         if (wrAt(REG_RESTART_DLY)) restartDelay_q <= regWrData[15:0];
         if (wrAt(REG_CHAN_SEL)) chanSel_q <= regWrData[CW-1:0];
         if (wrAt(REG_IRQ_MASK)) irqMask_q <= regWrData[IRQ_W-1:0];
         if (wrAt(REG_TAB_ADDR)) tabAddr_q <= regWrData[TAB_AW-1:0];
         else if (wrAt(REG_TAB_DATA)) tabAddr_q <= tabAddr_q + 1'b1;
         if (wrAt(REG_CH_TABLE)) cfg_q[chanSel_q].tableBase <= regWrData[TAB_AW-1:0];
         if (wrAt(REG_CH_REPEAT)) cfg_q[chanSel_q].repeatCount <= regWrData[7:0];
         if (wrAt(REG_CH_TARGET) && !running_q[chanSel_q]) begin
            cfg_q[chanSel_q].hostTarget <= regWrData[TEMP_W-1:0];
            cfg_q[chanSel_q].hostEnable <= regWrData[TARGET_EN_BIT];
         end
      end
   end

   // Read port, data valid only the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regRdData_q <= 32'h0;
      end else if (regRead) begin
         case (regAddr)
            REG_CTRL: regRdData_q <= {30'h0, ctrl_q};
            REG_STATUS: regRdData_q <= {14'h0, dirty_q, errorState_q,
                                        16'(running_q)};
            REG_IRQ_STAT: regRdData_q <= {28'h0, irqStat_q};
            REG_IRQ_MASK: regRdData_q <= {28'h0, irqMask_q};
            REG_TAB_ADDR: regRdData_q <= {24'h0, tabAddr_q};
            REG_CHAN_SEL: regRdData_q <= 32'(chanSel_q);
            REG_CH_TABLE: regRdData_q <= {8'h0, pc_q[chanSel_q], 8'h0,
                                          cfg_q[chanSel_q].tableBase};
            REG_CH_REPEAT: regRdData_q <= {8'h0, repLeft_q[chanSel_q], 8'h0,
                                           cfg_q[chanSel_q].repeatCount};
            REG_CH_TARGET: regRdData_q <= {cfg_q[chanSel_q].hostEnable, 3'h0,
                                           targetOut_q[chanSel_q],
                                           4'h0, cfg_q[chanSel_q].hostTarget};
            REG_RESTART_DLY: regRdData_q <= {16'h0, restartDelay_q};
            REG_ERR_INFO: regRdData_q <= errInfo_q;
            REG_DEV_TEMP: regRdData_q <= {20'h0, tempSample_q};
            REG_CUR_LIMIT: regRdData_q <= {16'h0, currentLimit_q};
            default: regRdData_q <= 32'h0;
         endcase
      end else begin
         regRdData_q <= 32'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tickCnt_q <= 24'h0;
         tick_q <= 1'b0;
         msCnt_q <= 10'h0;
         secTick_q <= 1'b0;
      end else begin
         tick_q <= (tickCnt_q == 24'(TICK_CYC - 1));
         tickCnt_q <= (tickCnt_q == 24'(TICK_CYC - 1)) ? 24'h0 : tickCnt_q + 24'h1;
         secTick_q <= tick_q && (msCnt_q == 10'(TICKS_PER_S - 1));
         if (tick_q) begin
            msCnt_q <= (msCnt_q == 10'(TICKS_PER_S - 1)) ? 10'h0 : msCnt_q + 10'h1;
         end
      end
   end

   // save delay restarted by each change
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         flashCnt_q <= 16'h0;
         dirty_q <= 1'b0;
         flashSave_q <= 1'b0;
      end else begin
         flashSave_q <= 1'b0;
         if (paramChange) begin
            dirty_q <= 1'b1;
            flashCnt_q <= 16'(FLASH_TICKS);
         end else if (!ctrl_q[CTRL_FLASH_EN_BIT]) begin
            flashCnt_q <= 16'(FLASH_TICKS);
         end else if (dirty_q && tick_q) begin
            if (flashCnt_q <= 16'h1) begin
               flashSave_q <= 1'b1;
               dirty_q <= 1'b0;
               flashCnt_q <= 16'h0;
            end else begin
               flashCnt_q <= flashCnt_q - 16'h1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sampleCnt_q <= 16'h0;
         tempSample_q <= '0;
         currentLimit_q <= CUR_MAX;
      end else begin
         if (tick_q) begin
            sampleCnt_q <= (sampleCnt_q == 16'(SAMPLE_TICKS - 1)) ? 16'h0
                                                                  : sampleCnt_q + 16'h1;
            if (sampleCnt_q == 16'h0) tempSample_q <= deviceTemp;
         end
         currentLimit_q <= ctrl_q[CTRL_EXT_MODE_BIT] ? derated : CUR_MAX;
      end
   end

   // fixed limit trip only in standard mode
   assign errorEvt = !errorState_q && (faultEvent ||
                     (!ctrl_q[CTRL_EXT_MODE_BIT] && tempSample_q >= TEMP_LIMIT));
   assign restartEvt = errorState_q && secTick_q && restartDelay_q != 16'h0 &&
                       upSec_q >= 5'(HOLDOFF_S) && errSec_q + 16'h1 >= restartDelay_q;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         errorState_q <= 1'b0;
         errInfo_q <= '0;
         errSec_q <= 16'h0;
         upSec_q <= 5'h0;
      end else begin
         if (secTick_q && upSec_q < 5'(HOLDOFF_S)) upSec_q <= upSec_q + 5'h1;
         if (errorEvt) begin
            errorState_q <= 1'b1;
            errSec_q <= 16'h0;
            errInfo_q <= faultEvent ? faultInfo
                                    : '{num: ERR_OVERTEMP, inst: DEVICE_INSTANCE,
                                        param: 16'(tempSample_q)};
         end else if (restartEvt) begin
            errorState_q <= 1'b0;
            errSec_q <= 16'h0;
         end else if (errorState_q && secTick_q) begin
            errSec_q <= (errSec_q == 16'hffff) ? errSec_q : errSec_q + 16'h1;
         end
      end
   end

   // Profile sequencer
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         seq_q <= SEQ_IDLE;
         cur_q <= '0;
         running_q <= '0;
         outEnable_q <= '0;
         savedEnable_q <= '0;
         doneEvt_q <= '0;
         lineLast_q <= '0;
         for (int c = 0; c < NCH; c++) begin
            pc_q[c] <= '0;
            repLeft_q[c] <= 8'h0;
            wait_q[c] <= 16'h0;
            savedTarget_q[c] <= '0;
            targetOut_q[c] <= '0;
         end
      end else begin
         lineLast_q <= generalInputLine;
         doneEvt_q <= '0;
         case (seq_q)
            SEQ_IDLE: begin
               if (candFound) begin
                  cur_q <= candIdx;
                  seq_q <= SEQ_READ;
               end
            end
            SEQ_READ: seq_q <= SEQ_EXEC;
            SEQ_EXEC: begin
               seq_q <= SEQ_IDLE;
               case (entry.op)
                  OP_END: begin
                     if (repLeft_q[cur_q] > 8'h1) begin
                        repLeft_q[cur_q] <= repLeft_q[cur_q] - 8'h1;
                        pc_q[cur_q] <= '0;
                     end else begin
                        running_q[cur_q] <= 1'b0;
                        doneEvt_q[cur_q] <= 1'b1;
                        targetOut_q[cur_q] <= savedTarget_q[cur_q];
                        outEnable_q[cur_q] <= savedEnable_q[cur_q];
                     end
                  end
                  OP_SET: begin
                     targetOut_q[cur_q] <= entry.field1;
                     if (entry.hasField2) wait_q[cur_q] <= 16'(entry.field2);
                     pc_q[cur_q] <= pc_q[cur_q] + 1'b1;
                  end
                  OP_WAIT: begin
                     wait_q[cur_q] <= 16'(entry.field1);
                     pc_q[cur_q] <= pc_q[cur_q] + 1'b1;
                  end
                  default: pc_q[cur_q] <= pc_q[cur_q] + 1'b1;
               endcase
            end
            default: seq_q <= SEQ_IDLE;
         endcase
         for (int c = 0; c < NCH; c++) begin
            if (tick_q && wait_q[c] != 16'h0 &&
                !(seq_q == SEQ_EXEC && cur_q == CW'(c))) begin
               wait_q[c] <= wait_q[c] - 16'h1;
            end
            if (!running_q[c]) begin
               targetOut_q[c] <= cfg_q[c].hostTarget;
               outEnable_q[c] <= cfg_q[c].hostEnable;
            end
            if (startReq[c] && !running_q[c] && cfg_q[c].repeatCount != 8'h0) begin
               running_q[c] <= 1'b1;
               pc_q[c] <= '0;
               wait_q[c] <= 16'h0;
               repLeft_q[c] <= cfg_q[c].repeatCount;
               savedTarget_q[c] <= cfg_q[c].hostTarget;
               savedEnable_q[c] <= cfg_q[c].hostEnable;
               outEnable_q[c] <= 1'b1;
            end
            if (stopReq[c] && running_q[c]) begin
               running_q[c] <= 1'b0;
               doneEvt_q[c] <= 1'b1;
               targetOut_q[c] <= savedTarget_q[c];
               outEnable_q[c] <= savedEnable_q[c];
               wait_q[c] <= 16'h0;
            end
         end
      end
   end

   // Sticky events, set wins over the clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irqStat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         irqStat_q <= (irqStat_q & ~(wrAt(REG_IRQ_STAT) ? regWrData[IRQ_W-1:0] : '0)) |
                      {restartEvt, errorEvt, flashSave_q, |doneEvt_q};
         irq_q <= |(irqStat_q & irqMask_q);
      end
   end
endmodule

/* File: verilog/supervisor_pkg.sv */
// Purpose: shared constants and types of the supervisory control block
// Assumes: 25 MHz clock, plain register port with word indices
// Notes: Function
// Function
// - Software commands select a table, set repeats, start, stop and read status.
// - A rising general input line starts table processing of its channel.
// - Each channel holds a table base and an execution count.
// - A running channel ignores every other target setting.
// - At the end or on a stop the channel gets its earlier state back.
// - An entry is an opcode, a first operand and an optional second operand.
// - Each parameter write takes effect at once with no commit step.
// - With saving enabled each change restarts a delay, then changes are saved.
// - With saving disabled no save request is ever raised.
// - Device temperature is sampled periodically and the latest sample is used.
// - Standard mode raises the overtemperature error at a fixed limit.
// - Extended mode derates the current limit with temperature instead.
// - The error state is left automatically after a programmable delay.
// - A delay of zero disables the automatic restart.
// - After power-up no automatic restart happens for a fixed interval.
// - Each error carries a number, an instance and a parameter.
package supervisor_pkg;

   localparam int TAB_AW = 8;
   localparam int TEMP_W = 12;

   // Register indices
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h01;
   localparam logic [7:0] REG_STATUS = 8'h02;
   localparam logic [7:0] REG_IRQ_STAT = 8'h03;
   localparam logic [7:0] REG_IRQ_MASK = 8'h04;
   localparam logic [7:0] REG_TAB_ADDR = 8'h05;
   localparam logic [7:0] REG_TAB_DATA = 8'h06;
   localparam logic [7:0] REG_CHAN_SEL = 8'h07;
   localparam logic [7:0] REG_CH_TABLE = 8'h08;
   localparam logic [7:0] REG_CH_REPEAT = 8'h09;
   localparam logic [7:0] REG_CH_TARGET = 8'h0a;
   localparam logic [7:0] REG_RESTART_DLY = 8'h0b;
   localparam logic [7:0] REG_ERR_INFO = 8'h0c;
   localparam logic [7:0] REG_DEV_TEMP = 8'h0d;
   localparam logic [7:0] REG_CUR_LIMIT = 8'h0e;

   // Field positions
   localparam int CTRL_FLASH_EN_BIT = 0;
   localparam int CTRL_EXT_MODE_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam int CMD_START_BIT = 8;
   localparam int CMD_STOP_BIT = 9;
   localparam int TARGET_EN_BIT = 31;
   localparam int STAT_ERR_BIT = 16;
   localparam int STAT_DIRTY_BIT = 17;
   localparam int IRQ_W = 4;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_SAVED_BIT = 1;
   localparam int IRQ_ERROR_BIT = 2;
   localparam int IRQ_RESTART_BIT = 3;

   // Timing
   localparam int CLK_HZ = 25000000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
   localparam int TICKS_PER_S = 1000000 / TICK_US;
   localparam int FLASH_DELAY_MS = 500;
   localparam int FLASH_TICKS = FLASH_DELAY_MS * 1000 / TICK_US;
   localparam int HOLDOFF_S = 20;
   localparam int SAMPLE_MS = 100;
   localparam int SAMPLE_TICKS = SAMPLE_MS * 1000 / TICK_US;

   localparam logic [7:0] ERR_OVERTEMP = 8'h3c;
   localparam logic [7:0] DEVICE_INSTANCE = 8'h01;

   typedef enum logic [3:0] {
      OP_END = 4'h0,
      OP_SET = 4'h1,
      OP_WAIT = 4'h2
   } opcode_type;

   typedef struct packed {
      logic [3:0] op;
      logic [11:0] field1;
      logic [14:0] field2;
      logic hasField2;
   } entry_type;

   typedef struct packed {
      logic [7:0] num;
      logic [7:0] inst;
      logic [15:0] param;
   } errInfo_type;

   typedef struct packed {
      logic [TAB_AW-1:0] tableBase;
      logic [7:0] repeatCount;
      logic [TEMP_W-1:0] hostTarget;
      logic hostEnable;
   } chanCfg_type;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_READ = 3'b010,
      SEQ_EXEC = 3'b100
   } seqState_type;

endpackage

/* File: verilog/profile_mem.sv */
// Purpose: profile table store with separate write and read ports, registered read
// Assumes: at most one write and one read per cycle
// Notes: read data appear the cycle after the read enable
`timescale 1ns/1ps
module profile_mem #(
   parameter int DEPTH = 256,
   parameter int WIDTH = 32,
   parameter int AW = 8
) (
   // Clock
   input wire logic clk,
   // Write side
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   // Read side
   input wire logic rdEn,
   input wire logic [AW-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData_q
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (rdEn) begin
         rdData_q <= mem[rdAddr];
      end
   end
endmodule

/* File: dv/supervisor_chk.sv */
// Purpose: port checks of the supervisory control block
// Assumes: one clock, synchronous active-low reset
// Notes: bus shadows and counters stand in for long waits
`timescale 1ns/1ps
module supervisor_chk
   import supervisor_pkg::*;
#(
   parameter int NCH = 2,
   parameter int TICK_CYC = TICK_CYCLES,
   parameter logic [TEMP_W-1:0] TEMP_LIMIT = 12'h320
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdData_q,
   // Device temperature and outputs watched
   input wire logic [TEMP_W-1:0] deviceTemp,
   input wire logic [NCH-1:0] outEnable_q,
   input wire logic [NCH-1:0] running_q,
   input wire logic flashSave_q,
   input wire logic errorState_q
);
   localparam int SAVE_LO = (FLASH_TICKS - 1) * TICK_CYC - 2;
   localparam int HOT_CYC = (SAMPLE_TICKS + 2) * TICK_CYC + 6;
   localparam int HOLD_CYC = (HOLDOFF_S * TICKS_PER_S - 1) * TICK_CYC - 2;
   logic flashEn_q, extMode_q, dlyZero_q, paramWr;
   logic [31:0] sinceWr_q, hotCnt_q, upCnt_q;
   assign paramWr = regWrite && (regAddr inside {REG_CTRL, REG_CH_TABLE, REG_CH_REPEAT,
      REG_CH_TARGET, REG_RESTART_DLY, REG_TAB_DATA});
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         flashEn_q <= 1'b1;
         extMode_q <= 1'b0;
         dlyZero_q <= 1'b0;
      end else begin
         if (regWrite && regAddr == REG_CTRL) begin
            flashEn_q <= regWrData[CTRL_FLASH_EN_BIT];
            extMode_q <= regWrData[CTRL_EXT_MODE_BIT];
         end
         if (regWrite && regAddr == REG_RESTART_DLY) begin
            dlyZero_q <= regWrData[15:0] == 16'h0000;
         end
      end
   end
   // Counters avoid long unrolled repetitions
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sinceWr_q <= '0;
         hotCnt_q <= '0;
         upCnt_q <= '0;
      end else begin
         sinceWr_q <= paramWr ? 32'h0 : sinceWr_q + 32'h1;
         hotCnt_q <= (deviceTemp >= TEMP_LIMIT && !extMode_q && !errorState_q) ?
            hotCnt_q + 32'h1 : 32'h0;
         upCnt_q <= upCnt_q + 32'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence stopCmd;
      regWrite && regAddr == REG_CMD && regWrData[CMD_STOP_BIT] &&
         !regWrData[CMD_START_BIT] && regWrData[7:0] == 8'h01;
   endsequence
   a_stop_clears: assert property (stopCmd |=> !running_q[1])
      else $error("channel still running after stop");
   a_run_enable: assert property (running_q[0] |-> outEnable_q[0])
      else $error("running channel not enabled");
   a_read_gap: assert property (!$past(regRead) |-> regRdData_q == 32'h0)
      else $error("read data outside its cycle");
   a_unmapped_zero: assert property (regRead && regAddr > REG_CUR_LIMIT |=> regRdData_q == 32'h0)
      else $error("unmapped read not zero");
   a_save_off: assert property (!flashEn_q && !$past(flashEn_q) |-> !flashSave_q)
      else $error("save while saving disabled");
   a_save_delay: assert property (flashSave_q |-> sinceWr_q >= SAVE_LO)
      else $error("save came too early");
   a_temp_trip: assert property (hotCnt_q == HOT_CYC |-> errorState_q)
      else $error("no overtemperature error");
   a_zero_holds: assert property (dlyZero_q && errorState_q && !regWrite |=> errorState_q)
      else $error("restart with zero delay");
   a_holdoff: assert property ($fell(errorState_q) |-> upCnt_q >= HOLD_CYC)
      else $error("restart inside power-up holdoff");
endmodule
bind supervisor_profile_flash_ctl supervisor_chk #(.NCH(NCH), .TICK_CYC(TICK_CYC),
   .TEMP_LIMIT(TEMP_LIMIT)) chk (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
   .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
   .regRdData_q(regRdData_q), .deviceTemp(deviceTemp), .outEnable_q(outEnable_q),
   .running_q(running_q), .flashSave_q(flashSave_q), .errorState_q(errorState_q));

/* File: dv/flash_store_model.sv */
// Purpose: far-side flash store, counts saved images
// Assumes: one save per request pulse
// Notes: contents are not modelled
`timescale 1ns/1ps
module flash_store_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Save request
   input wire logic flashSave_q,
   // Images stored
   output int saveCount
);
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         saveCount <= 0;
      end else if (flashSave_q) begin
         saveCount <= saveCount + 1;
      end
   end
endmodule

/* File: dv/tb_top.sv */
// Purpose: self-checking bench of the supervisory control block
// Assumes: tick of 2 cycles so seconds pass quickly
// Notes: read results are checked by a watcher against a queue
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin badCount++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
`define WAITC(c, n) for (int k = 0; k < (n) && !(c); k++) @(posedge clk);
module tb_top
   import supervisor_pkg::*;
;
   logic clk, reset_n, regWrite, regRead, faultEvent, rdPend, flashSave_q, errorState_q, irq_q;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData_q;
   logic [1:0] generalInputLine, outEnable_q, running_q;
   logic [TEMP_W-1:0] deviceTemp, tgt;
   logic [1:0][TEMP_W-1:0] targetOut_q;
   logic [15:0] currentLimit_q;
   errInfo_type faultInfo;
   logic [63:0] expQ[$];
   int saveCount, checks, badCount, cyc, seed;
   supervisor_profile_flash_ctl #(.TICK_CYC(2)) dut (.clk, .reset_n, .regAddr, .regWrData,
      .regWrite, .regRead, .regRdData_q, .generalInputLine, .deviceTemp, .faultEvent,
      .faultInfo, .targetOut_q, .outEnable_q, .running_q, .currentLimit_q, .flashSave_q,
      .errorState_q, .irq_q);
   flash_store_model store (.clk, .reset_n, .flashSave_q, .saveCount);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      expQ.push_back({m, e});
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(posedge clk);
   endtask
   task automatic completeRun();
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         badCount++;
         completeRun();
      end
   end
   // Read data stand only in the cycle after the strobe
   always @(posedge clk) begin
      if (rdPend && expQ.size() > 0) begin
         `CHK(regRdData_q & expQ[0][63:32], expQ[0][31:0])
         void'(expQ.pop_front());
      end
      rdPend <= regRead;
   end
   initial begin
      seed = 72435;
      {regWrite, regRead, faultEvent, rdPend, reset_n} = '0;
      regAddr = 8'h00;
      regWrData = 32'h0;
      generalInputLine = 2'b00;
      deviceTemp = 12'h100;
      faultInfo = '0;
      tgt = 12'($random(seed));
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(REG_CTRL, 32'h1, 32'h3);
      wr(8'h3f, $random(seed));
      rd(8'h3f, 32'h0, 32'hffffffff);
      wr(REG_IRQ_MASK, 32'h1);
      wr(REG_RESTART_DLY, 32'h1);
      wr(REG_TAB_ADDR, 32'h0);
      wr(REG_TAB_DATA, {OP_SET, tgt, 15'h0010, 1'b1});
      wr(REG_TAB_DATA, {OP_END, 28'h0});
      wr(REG_CH_TABLE, 32'h0);
      wr(REG_CH_REPEAT, 32'h1);
      wr(REG_CH_TARGET, 32'h8000_0050);
      wr(REG_CMD, 32'h100);
      `CHK(running_q[0], 1'b1)
      wr(REG_CH_TARGET, 32'h0000_0111);
      `WAITC(targetOut_q[0] === tgt, 30)
      `CHK({outEnable_q[0], targetOut_q[0]}, {1'b1, tgt})
      `WAITC(running_q[0] === 1'b0, 200)
      `CHK({outEnable_q[0], targetOut_q[0]}, {1'b1, 12'h050})
      rd(REG_CH_TARGET, 32'h8050_0050, 32'h8fff_0fff);
      `CHK(irq_q, 1'b1)
      rd(REG_IRQ_STAT, 32'h1, 32'h1);
      wr(REG_IRQ_STAT, 32'h1);
      @(posedge clk);
      `CHK(irq_q, 1'b0)
      wr(REG_CHAN_SEL, 32'h1);
      wr(REG_CH_REPEAT, 32'h2);
      generalInputLine <= 2'b10;
      `WAITC(running_q[1] === 1'b1, 4)
      `CHK(running_q[1], 1'b1)
      rd(REG_CH_REPEAT, 32'h2, 32'hff);
      wr(REG_CMD, 32'h201);
      `CHK(running_q[1], 1'b0)
      generalInputLine <= 2'b00;
      wr(REG_IRQ_STAT, 32'hf);
      `WAITC(saveCount == 1, 1200)
      `CHK(saveCount, 1)
      `CHK(irq_q, 1'b0)
      rd(REG_IRQ_STAT, 32'h2, 32'h2);
      wr(REG_CTRL, 32'h0);
      wr(REG_CH_REPEAT, 32'h3);
      repeat (1500) @(posedge clk);
      `CHK(saveCount, 1)
      rd(REG_STATUS, 32'h2_0000, 32'h2_0000);
      wr(REG_CTRL, 32'h2);
      deviceTemp <= 12'h320;
      repeat (300) @(posedge clk);
      `CHK(errorState_q, 1'b0)
      `CHK(currentLimit_q < 16'h0fa0, 1'b1)
      wr(REG_CTRL, 32'h0);
      `WAITC(errorState_q === 1'b1, 400)
      `CHK(errorState_q, 1'b1)
      rd(REG_ERR_INFO, {ERR_OVERTEMP, DEVICE_INSTANCE, 16'h0320}, 32'hffffffff);
      deviceTemp <= 12'($random(seed)) & 12'h1ff;
      while (cyc < 38000) @(posedge clk);
      `CHK(errorState_q, 1'b1)
      `WAITC(errorState_q === 1'b0, 5000)
      `CHK(errorState_q, 1'b0)
      wr(REG_RESTART_DLY, 32'h0);
      faultInfo <= errInfo_type'($random(seed));
      faultEvent <= 1'b1;
      @(posedge clk);
      faultEvent <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(errorState_q, 1'b1)
      rd(REG_ERR_INFO, faultInfo, 32'hffffffff);
      repeat (4500) @(posedge clk);
      `CHK(errorState_q, 1'b1)
      completeRun();
   end
endmodule
